// File: tb/phy_control_bits_props.sv
// checker: port-level assertions for the phy control word bank
`timescale 1ns/1ps
module phy_control_bits_chk
  import phy_ctrl_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // transmit stream
  input wire logic        tx_in_valid,
  input wire logic [7:0]  tx_in_data,
  input wire logic        tx_in_last,
  input wire logic        tx_out_valid,
  input wire logic [7:0]  tx_out_data,
  input wire logic        tx_out_last,
  // control outputs
  input wire logic [1:0]  receive_mode_select,
  input wire logic        rx_path_reset,
  input wire logic        tx_path_reset,
  input wire logic        mem_chip_en,
  input wire logic        mem_out_en
);
  logic       csum_q;  // last written checksum enable
  logic       setup_q; // last written setup bit
  logic [1:0] mode_q;  // last written receive mode
  logic       wr_ctrl; // completed control word write
  logic       tx_go;   // byte the transmitter should accept
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
  assign tx_go = tx_in_valid && !mem_chip_en && !tx_path_reset;
  // shadow of the control fields, taken at the write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {csum_q, setup_q, mode_q} <= 4'h0;
    end else if (wr_ctrl) begin
      {setup_q, csum_q} <= pwdata[15:14];
      mode_q <= pwdata[11:10];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_GLOBAL_RESET: assert property (
    $rose(presetn) |-> rx_path_reset && tx_path_reset)
    else $error("path resets not held by global reset");
  AST_RX_RESET: assert property (
    wr_ctrl && pwdata[RX_RESET_BIT] |-> ##[1:2] rx_path_reset)
    else $error("receive path reset missing");
  AST_TX_RESET: assert property (
    wr_ctrl && pwdata[TX_RESET_BIT] |-> ##[1:2] tx_path_reset)
    else $error("transmit path reset missing");
  AST_SELF_CLEAR: assert property (
    $rose(rx_path_reset) |-> ##[1:12] !rx_path_reset)
    else $error("receive path reset never ends");
  AST_TX_SELF_CLEAR: assert property (
    $rose(tx_path_reset) |-> ##[1:12] !tx_path_reset)
    else $error("transmit path reset never ends");
  AST_MODE: assert property (
    wr_ctrl |=> ##[0:1] receive_mode_select == mode_q)
    else $error("receive mode not driven");
  AST_SETUP_MEM: assert property (
    wr_ctrl |=> ##[0:1] mem_chip_en == setup_q && mem_out_en == setup_q)
    else $error("memory enables not following setup");
  AST_SETUP_BLOCK: assert property (
    mem_chip_en && $past(mem_chip_en) |-> !tx_out_valid)
    else $error("transmit active in setup mode");
  AST_CRC_ON: assert property (
    tx_go && tx_in_last && csum_q |=> tx_out_valid && !tx_out_last
    ##1 tx_out_valid && !tx_out_last ##1 tx_out_valid && tx_out_last)
    else $error("checksum bytes not appended");
  AST_CRC_OFF: assert property (
    tx_go && tx_in_last && !csum_q |=> tx_out_valid && tx_out_last)
    else $error("frame end wrong without checksum");
  AST_TX_PASS: assert property (
    tx_go |=> tx_out_valid && tx_out_data == $past(tx_in_data))
    else $error("payload byte lost or changed");
  // main scenarios reached
  cover property (wr_ctrl && pwdata[RX_RESET_BIT]);
  cover property (tx_go && tx_in_last && csum_q);
  cover property (mem_chip_en && tx_in_valid);
endmodule
bind phy_control_bits phy_control_bits_chk chk (.pclk(pclk),
  .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .tx_in_valid(tx_in_valid),
  .tx_in_data(tx_in_data), .tx_in_last(tx_in_last),
  .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
  .tx_out_last(tx_out_last), .receive_mode_select(receive_mode_select),
  .rx_path_reset(rx_path_reset), .tx_path_reset(tx_path_reset),
  .mem_chip_en(mem_chip_en), .mem_out_en(mem_out_en));

// File: tb/test_phy_control_bits.sv
// testbench: register, path reset, checksum and interrupt scenarios
`timescale 1ns/1ps
module test_phy_control_bits
  import phy_ctrl_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic tx_in_valid, tx_in_last, tx_out_valid, tx_out_last, rerr;
  logic rx_in_valid, rx_in_last, rx_path_reset, tx_path_reset;
  logic [7:0] tx_in_data, rx_in_data, tx_out_data;
  logic [1:0] receive_mode_select;
  logic mem_chip_en, mem_out_en;
  logic [7:0] frame_b [5];  // payload then checksum bytes
  logic [8:0] txq [$];      // captured {last, data}
  logic [15:0] crc_x;
  logic [11:0] a;
  int fails, total_checks, cnt;
  typedef struct { logic [31:0] wd; logic [1:0] mode; logic setup; } row_t;
  // control words; code 11 is never written
  row_t rows [5] = '{'{32'h0000, 2'h0, 1'b0}, '{32'h0400, 2'h1, 1'b0},
    '{32'h0800, 2'h2, 1'b0}, '{32'h8400, 2'h1, 1'b1}, '{32'h4000, 2'h0, 1'b0}};

  phy_control_bits uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
    .tx_in_last(tx_in_last), .tx_out_valid(tx_out_valid),
    .tx_out_data(tx_out_data), .tx_out_last(tx_out_last),
    .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
    .rx_in_last(rx_in_last), .receive_mode_select(receive_mode_select),
    .rx_path_reset(rx_path_reset), .tx_path_reset(tx_path_reset),
    .mem_chip_en(mem_chip_en), .mem_out_en(mem_out_en), .irq(irq));

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // line bytes stand one cycle, so every edge is captured
  always @(posedge pclk) begin
    if (tx_out_valid === 1'b1) txq.push_back({tx_out_last, tx_out_data});
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // apb transfer; waits for pready under a bound, never assumes latency
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask
  task automatic rd(input logic [11:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask
  // one frame on either stream; idle gap covers the checksum cycles
  task automatic send(input logic to_rx, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      if (to_rx) begin
        {rx_in_valid, rx_in_data} <= {1'b1, frame_b[i]};
        rx_in_last <= (i == n - 1);
      end else begin
        {tx_in_valid, tx_in_data} <= {1'b1, frame_b[i]};
        tx_in_last <= (i == n - 1);
      end
    end
    @(posedge pclk);
    {rx_in_valid, tx_in_valid, rx_in_last, tx_in_last} <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask
  // bench's own msb-first checksum step
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic tx_case(input logic on);
    wr(ADDR_CTRL, {17'h0, on, 14'h0});
    txq.delete();
    send(1'b0, 3);
    chk(txq.size(), on ? 5 : 3);
    for (int i = 0; i < 3; i++) begin
      chk(txq[i], {!on && i == 2, frame_b[i]});
    end
    if (on) begin
      chk(txq[3], {1'b0, crc_x[15:8]});
      chk(txq[4], {1'b1, crc_x[7:0]});
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_of_test;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_in_valid, tx_in_last, tx_in_data} = '0;
    {rx_in_valid, rx_in_last, rx_in_data} = '0;
    presetn = 1'b0;
    frame_b = '{8'h31, 8'h32, 8'h33, 8'h00, 8'h00};
    crc_x = CRC_INIT;
    for (int i = 0; i < 3; i++) crc_x = crc_step(crc_x, frame_b[i]);
    {frame_b[3], frame_b[4]} = crc_x;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL_TWO);
    chk(rdat[7:0], CTRL_TWO_RESET);
    chk({rerr, rx_path_reset, tx_path_reset, irq}, 4'h0);
    // protected registers: locked, then open in setup mode
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? ADDR_MEM_PTR : (k == 1) ? ADDR_MEM_WIN : ADDR_TX_POWER;
      wr(a, 32'h5A);
      rd(a);
      chk(rdat[7:0], BYTE_RESET);
      wr(ADDR_CTRL, 32'h8000);
      wr(a, 32'h5A);
      rd(a);
      chk(rdat[7:0], 8'h5A);
      wr(ADDR_CTRL, 32'h0);
    end
    // ordinary control words from the table
    foreach (rows[i]) begin
      wr(ADDR_CTRL, rows[i].wd);
      repeat (2) @(posedge pclk);
      chk(receive_mode_select, rows[i].mode);
      chk({mem_chip_en, mem_out_en}, {2{rows[i].setup}});
      rd(ADDR_CTRL);
      chk(rdat & 32'hFC00, rows[i].wd);
    end
    // self-clearing path resets; each must last the full hold time
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, 32'h1000 << k);
      cnt = 0;
      repeat (16) begin
        @(posedge pclk);
        if ((k ? tx_path_reset : rx_path_reset) === 1'b1) cnt++;
      end
      chk(cnt >= PATH_RESET_CYC, 1'b1);
      rd(ADDR_CTRL);
      chk(rdat[13:12], 2'h0);
    end
    // checksum on, off, then on again to catch a stale remainder
    tx_case(1'b1);
    tx_case(1'b0);
    tx_case(1'b1);
    wr(ADDR_CTRL, 32'h8000);
    txq.delete();
    send(1'b0, 3);
    chk(txq.size(), 0);
    wr(ADDR_CTRL, 32'h0);
    // receive check with transmit checksum off, then a bad frame
    wr(ADDR_IRQ_MASK, 32'h0);
    send(1'b1, 5);
    rd(ADDR_STATUS);
    chk(rdat[0], 1'b1);
    frame_b[4] ^= 8'h01;
    // the bad frame is dropped in setup mode, so the flag stays good
    wr(ADDR_CTRL, 32'h8000);
    send(1'b1, 5);
    rd(ADDR_STATUS);
    chk(rdat[0], 1'b1);
    wr(ADDR_CTRL, 32'h0);
    send(1'b1, 5);
    rd(ADDR_STATUS);
    chk(rdat[0], 1'b0);
    rd(ADDR_IRQ_STAT);
    chk({rdat[0], irq}, 2'h2);
    wr(ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rd(12'h0FC);
    chk(rerr, 1'b1);
    // second reset in mid-run
    wr(ADDR_CTRL_TWO, 32'h0B);
    wr(ADDR_CTRL, 32'h0800);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1 chk({rx_path_reset, tx_path_reset}, 2'h3);
    chk(receive_mode_select, 2'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL_TWO);
    chk(rdat[7:0], CTRL_TWO_RESET);
    end_of_test;
  end
endmodule

// File: verilog/crc16_unit.sv
// module: bytewise crc16 engine, instanced once for transmit append and once for receive check
`timescale 1ns/1ps
module crc16_unit
  import phy_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        clear,
  input  wire logic        byte_en,
  input  wire logic [7:0]  byte_in,
  // result
  output logic [15:0]      crc
);

  logic [15:0] crc_q, crc_d;   // running remainder

  // one byte per cycle, msb first
  always_comb begin
    logic [15:0] c;
    c = crc_q;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ byte_in[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    if (clear) begin
      crc_d = CRC_INIT;
    end else if (byte_en) begin
      crc_d = c;
    end else begin
      crc_d = crc_q;
    end
  end

  // register the remainder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;

endmodule

// File: verilog/path_reset_timer.sv
// module: self-clearing path reset sequencer for one phy path
`timescale 1ns/1ps
module path_reset_timer
  import phy_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // software request and results
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  typedef enum logic [1:0] {IDLE, HOLD, FINISH} rst_state_t;

  rst_state_t state_q, state_d;   // sequencer state
  logic [3:0] cnt_q, cnt_d;       // cycles spent in hold

  // next state: hold the path in reset for the fixed count, then report
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      IDLE: begin
        if (start) begin
          state_d = HOLD;
          cnt_d   = 4'h0;
        end
      end
      HOLD: begin
        if (cnt_q == PATH_RESET_LAST) begin
          state_d = FINISH;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      FINISH: begin
        state_d = IDLE;
      end
    endcase
  end

  // register the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= IDLE;
      cnt_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign busy = (state_q == HOLD);
  assign done = (state_q == FINISH);

endmodule

// File: verilog/phy_control_bits.sv
// module: phy control word bank with path resets, crc16 and setup mode lock
//
// Summary of operation
// - rx mode: auto, normal, robust, invalid
// - control bit 12 resets receive path
// - control bit 13 resets transmit path
// - path reset is soft bit or global
// - hardware clears path reset bit when done
// - bit 14 set appends crc16 to frames
// - bit 14 clear sends payload only
// - receiver checks last two bytes outside setup mode and receive path reset
// - crc mismatch clears checksum good flag
// - bit 15 forces memory enables active
// - setup mode blocks transmit and receive
// - protected registers writable only in setup
// - global reset clears control word two
`timescale 1ns/1ps
module phy_control_bits
  import phy_ctrl_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // transmit byte stream in (payload) and out (line)
  input  wire logic        tx_in_valid,
  input  wire logic [7:0]  tx_in_data,
  input  wire logic        tx_in_last,
  output logic             tx_out_valid,
  output logic [7:0]       tx_out_data,
  output logic             tx_out_last,
  // received byte stream (crc bytes included)
  input  wire logic        rx_in_valid,
  input  wire logic [7:0]  rx_in_data,
  input  wire logic        rx_in_last,
  // phy control outputs
  output logic [1:0]       receive_mode_select,
  output logic             rx_path_reset,
  output logic             tx_path_reset,
  output logic             mem_chip_en,
  output logic             mem_out_en,
  // interrupt
  output logic             irq
);

  // register state
  logic [15:0] ctrl_q, ctrl_d;           // phy_control_word
  logic [7:0]  ctrl2_q, ctrl2_d;         // phy_control_word_two
  logic [7:0]  mptr_q, mptr_d;           // phy_memory_pointer
  logic [7:0]  mwin_q, mwin_d;           // phy_memory_window
  logic [7:0]  transmit_power_control_q, transmit_power_control_d;           // transmit_power_control
  logic        good_q, good_d;           // checksum_good_flag
  logic [IRQ_BITS-1:0] ist_q, ist_d;     // sticky interrupt status
  logic [IRQ_BITS-1:0] imask_q, imask_d; // interrupt mask
  logic [31:0] rdata_q, rdata_d;         // read data register
  logic        ready_q, ready_d;         // answer strobe
  logic        err_q, err_d;             // unmapped answer
  logic        irq_q, irq_d;             // interrupt level

  // datapath state
  logic        tx_crc_q, tx_crc_d;       // appending crc bytes
  logic        tx_hi_q, tx_hi_d;         // next crc byte is the high one
  logic        tvalid_q, tvalid_d;
  logic [7:0]  tdata_q, tdata_d;
  logic        tlast_q, tlast_d;
  logic [15:0] rx_tail_q, rx_tail_d;     // last two received bytes
  logic [1:0]  rx_cnt_q, rx_cnt_d;       // bytes seen, saturates at two
  logic        rrst_q, rrst_d, trst_q, trst_d;

  // helpers
  logic        wr_en, rd_en, setup, tx_ok, rx_ok;
  logic        rx_busy, rx_done, tx_busy, tx_done;
  logic [15:0] tx_crc, rx_crc;
  logic        frame_end;
  logic        tx_plain_end;             // payload-only frame ends
  logic        crc_fail;

  assign wr_en = psel && penable && pwrite && !ready_q;
  assign rd_en = psel && penable && !pwrite && !ready_q;
  assign setup = ctrl_q[SETUP_MODE_BIT];
  assign tx_ok = !setup && !trst_q;
  assign rx_ok = !setup && !rrst_q;

  // path reset sequencers; software bit starts each one
  path_reset_timer u_rx_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (ctrl_q[RX_RESET_BIT] && !rx_busy && !rx_done),
    .busy    (rx_busy),
    .done    (rx_done)
  );
  path_reset_timer u_tx_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (ctrl_q[TX_RESET_BIT] && !tx_busy && !tx_done),
    .busy    (tx_busy),
    .done    (tx_done)
  );

  // transmit crc consumes each payload byte accepted
  crc16_unit u_tx_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!tx_ok || (tx_crc_q && !tx_hi_q) || tx_plain_end),
    .byte_en (tx_ok && tx_in_valid && !tx_crc_q),
    .byte_in (tx_in_data),
    .crc     (tx_crc)
  );

  // receive crc runs two bytes behind the stream so the tail is excluded
  crc16_unit u_rx_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!rx_ok || frame_end),
    .byte_en (rx_ok && rx_in_valid && rx_cnt_q == 2'h2),
    .byte_in (rx_tail_q[15:8]),
    .crc     (rx_crc)
  );

  assign frame_end = rx_ok && rx_in_valid && rx_in_last;
  // a payload-only frame must not leave its remainder to the next frame
  assign tx_plain_end = tx_in_valid && tx_in_last && !tx_crc_q &&
                        !ctrl_q[CSUM_EN_BIT];
  // compare the remainder against the final two bytes
  assign crc_fail = (rx_cnt_q == 2'h2) ?
    ({rx_tail_q[7:0], rx_in_data} != rx_crc_next(rx_crc, rx_tail_q[15:8]))
    : 1'b1;

  // remainder including the byte being retired this cycle
  function automatic logic [15:0] rx_crc_next(input logic [15:0] c_in,
                                              input logic [7:0]  b);
    logic [15:0] c;
    c = c_in;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ b[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // register bank next values
  always_comb begin
    ctrl_d  = ctrl_q;
    ctrl2_d = ctrl2_q;
    mptr_d  = mptr_q;
    mwin_d  = mwin_q;
    transmit_power_control_d  = transmit_power_control_q;
    imask_d = imask_q;
    ist_d   = ist_q;
    good_d  = good_q;
    ready_d = psel && penable && !ready_q;
    err_d   = 1'b0;
    rdata_d = 32'h0000_0000;
    // software writes; w1c on interrupt status
    if (wr_en) begin
      unique case (paddr)
        ADDR_CTRL:     ctrl_d  = pwdata[15:0];
        ADDR_CTRL_TWO: ctrl2_d = pwdata[7:0];
        ADDR_MEM_PTR:  if (setup) mptr_d = pwdata[7:0];
        ADDR_MEM_WIN:  if (setup) mwin_d = pwdata[7:0];
        ADDR_TX_POWER: if (setup) transmit_power_control_d = pwdata[7:0];
        ADDR_IRQ_STAT: ist_d = ist_q & ~pwdata[IRQ_BITS-1:0];
        ADDR_IRQ_MASK: imask_d = pwdata[IRQ_BITS-1:0];
        ADDR_STATUS:   ;  // status writes change nothing
        default:       err_d = 1'b1;
      endcase
    end
    // reads
    if (rd_en) begin
      unique case (paddr)
        ADDR_CTRL:     rdata_d = {16'h0000, ctrl_q};
        ADDR_CTRL_TWO: rdata_d = {24'h000000, ctrl2_q};
        ADDR_MEM_PTR:  rdata_d = {24'h000000, mptr_q};
        ADDR_MEM_WIN:  rdata_d = {24'h000000, mwin_q};
        ADDR_TX_POWER: rdata_d = {24'h000000, transmit_power_control_q};
        ADDR_STATUS:   rdata_d = {31'h00000000, good_q};
        ADDR_IRQ_STAT: rdata_d = {29'h00000000, ist_q};
        ADDR_IRQ_MASK: rdata_d = {29'h00000000, imask_q};
        default:       err_d = 1'b1;
      endcase
    end
    // hardware clears the path reset bits when complete (wins over write)
    if (rx_done) begin
      ctrl_d[RX_RESET_BIT] = 1'b0;
    end
    if (tx_done) begin
      ctrl_d[TX_RESET_BIT] = 1'b0;
    end
    // frame end updates checksum good and events; set wins over clear
    if (frame_end) begin
      good_d = !crc_fail;
      ist_d[IRQ_RX_DONE] = 1'b1;
      if (crc_fail) begin
        ist_d[IRQ_CSUM_FAIL] = 1'b1;
      end
    end
    if (tvalid_q && tlast_q) begin
      ist_d[IRQ_TX_DONE] = 1'b1;
    end
    irq_d = |(ist_d & imask_d);
  end

  // transmit path and receive tail next values
  always_comb begin
    tx_crc_d  = tx_crc_q;
    tx_hi_d   = tx_hi_q;
    tvalid_d  = 1'b0;
    tdata_d   = tdata_q;
    tlast_d   = 1'b0;
    rx_tail_d = rx_tail_q;
    rx_cnt_d  = rx_cnt_q;
    rrst_d    = ctrl_q[RX_RESET_BIT] || rx_busy;
    trst_d    = ctrl_q[TX_RESET_BIT] || tx_busy;
    if (!tx_ok) begin
      tx_crc_d = 1'b0;
      tx_hi_d  = 1'b0;
    end else if (tx_crc_q) begin
      // crc bytes follow the payload, high byte first
      tvalid_d = 1'b1;
      tdata_d  = tx_hi_q ? tx_crc[15:8] : tx_crc[7:0];
      tlast_d  = !tx_hi_q;
      tx_hi_d  = 1'b0;
      tx_crc_d = tx_hi_q;
    end else if (tx_in_valid) begin
      tvalid_d = 1'b1;
      tdata_d  = tx_in_data;
      if (tx_in_last && ctrl_q[CSUM_EN_BIT]) begin
        tx_crc_d = 1'b1;
        tx_hi_d  = 1'b1;
      end else begin
        tlast_d  = tx_in_last;  // payload only
      end
    end
    if (!rx_ok || frame_end) begin
      rx_cnt_d  = 2'h0;
      rx_tail_d = 16'h0000;
    end else if (rx_in_valid) begin
      rx_tail_d = {rx_tail_q[7:0], rx_in_data};
      if (rx_cnt_q != 2'h2) begin
        rx_cnt_d = rx_cnt_q + 2'h1;
      end
    end
  end

  // register everything; global reset clears all but the path resets, which it sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RESET;
      ctrl2_q   <= CTRL_TWO_RESET;
      mptr_q    <= BYTE_RESET;
      mwin_q    <= BYTE_RESET;
      transmit_power_control_q    <= BYTE_RESET;
      good_q    <= 1'b0;
      ist_q     <= '0;
      imask_q   <= '0;
      rdata_q   <= 32'h0000_0000;
      ready_q   <= 1'b0;
      err_q     <= 1'b0;
      irq_q     <= 1'b0;
      tx_crc_q  <= 1'b0;
      tx_hi_q   <= 1'b0;
      tvalid_q  <= 1'b0;
      tdata_q   <= 8'h00;
      tlast_q   <= 1'b0;
      rx_tail_q <= 16'h0000;
      rx_cnt_q  <= 2'h0;
      rrst_q    <= 1'b1;
      trst_q    <= 1'b1;
    end else begin
      ctrl_q    <= ctrl_d;
      ctrl2_q   <= ctrl2_d;
      mptr_q    <= mptr_d;
      mwin_q    <= mwin_d;
      transmit_power_control_q    <= transmit_power_control_d;
      good_q    <= good_d;
      ist_q     <= ist_d;
      imask_q   <= imask_d;
      rdata_q   <= rdata_d;
      ready_q   <= ready_d;
      err_q     <= err_d;
      irq_q     <= irq_d;
      tx_crc_q  <= tx_crc_d;
      tx_hi_q   <= tx_hi_d;
      tvalid_q  <= tvalid_d;
      tdata_q   <= tdata_d;
      tlast_q   <= tlast_d;
      rx_tail_q <= rx_tail_d;
      rx_cnt_q  <= rx_cnt_d;
      rrst_q    <= rrst_d;
      trst_q    <= trst_d;
    end
  end

  // mode code 11 passes through untouched; software must avoid it
  assign receive_mode_select = ctrl_q[RX_MODE_HI:RX_MODE_LO];
  assign rx_path_reset = rrst_q;
  assign tx_path_reset = trst_q;
  // memories forced active in setup mode (registered via ctrl_q)
  assign mem_chip_en  = ctrl_q[SETUP_MODE_BIT];
  assign mem_out_en   = ctrl_q[SETUP_MODE_BIT];
  assign tx_out_valid = tvalid_q;
  assign tx_out_data  = tdata_q;
  assign tx_out_last  = tlast_q;
  assign pready  = ready_q;
  assign prdata  = rdata_q;
  assign pslverr = err_q;
  assign irq     = irq_q;

endmodule

// File: verilog/phy_ctrl_pkg.sv
// package: register map, field positions and timing counts for phy control
package phy_ctrl_pkg;

  // register indices (printed offset 0x05 is not a multiple of four)
  localparam logic [7:0] IDX_CTRL_TWO  = 8'h05;
  localparam logic [7:0] IDX_CTRL      = 8'h00;
  localparam logic [7:0] IDX_MEM_PTR   = 8'h01;
  localparam logic [7:0] IDX_MEM_WIN   = 8'h02;
  localparam logic [7:0] IDX_TX_POWER  = 8'h03;
  localparam logic [7:0] IDX_STATUS    = 8'h04;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h06;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h07;

  // byte addresses are four times the index
  localparam logic [11:0] ADDR_CTRL     = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_MEM_PTR  = {2'h0, IDX_MEM_PTR, 2'h0};
  localparam logic [11:0] ADDR_MEM_WIN  = {2'h0, IDX_MEM_WIN, 2'h0};
  localparam logic [11:0] ADDR_TX_POWER = {2'h0, IDX_TX_POWER, 2'h0};
  localparam logic [11:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_CTRL_TWO = {2'h0, IDX_CTRL_TWO, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

  // field positions of the control word
  localparam int RX_MODE_LO     = 10;
  localparam int RX_MODE_HI     = 11;
  localparam int RX_RESET_BIT   = 12;
  localparam int TX_RESET_BIT   = 13;
  localparam int CSUM_EN_BIT    = 14;
  localparam int SETUP_MODE_BIT = 15;

  // status and interrupt bit positions
  localparam int STAT_CSUM_GOOD = 0;
  localparam int IRQ_CSUM_FAIL  = 0;
  localparam int IRQ_RX_DONE    = 1;
  localparam int IRQ_TX_DONE    = 2;
  localparam int IRQ_BITS       = 3;

  // reset values
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [7:0]  CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'h1021;

  // path reset hold time and derived cycle count at 20 MHz
  localparam int PATH_RESET_NS   = 200;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int PATH_RESET_CYC  =
    (PATH_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PATH_RESET_LAST = 4'(PATH_RESET_CYC - 1);

  // receive mode codes
  typedef enum logic [1:0] {
    RX_AUTO   = 2'h0,
    RX_NORMAL = 2'h1,
    RX_ROBUST = 2'h2,
    RX_BAD    = 2'h3
  } rx_mode_t;

endpackage
